// File: rtl/adcsq_top.sv
// Conversion sequencer: registers, clock select, sleep and wake control
// Functional notes
// R1 - Software acquires channel before starting conversion
// R2 - Start flag bit 1, cleared at completion
// R3 - Software waits two bit periods between conversions
// R4 - RC clock delays start by one instruction
// R5 - Completion clears start flag, writes result pair
// R6 - Completion in sleep with enable wakes device
// R7 - Wake vectors if global enable, else resumes
// R8 - Sleep completion without enable powers converter off
// R9 - Non-RC clock: sleep aborts, converter off
// R10 - Reset turns off, aborts, resets control registers
// R11 - Result registers unknown at power-on, else kept
// R12 - Ten-bit result, left or right justified
// R13 - Done flag bit 6, enable bit 6, 7:6
// R14 - Software sets analog pins as inputs
// R15 - Software configures everything, then powers on
// R16 - Three-bit field selects conversion clock divider
// R17 - Fixed eleven bit periods per conversion
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic       CE,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Core state
  input  wire logic       SLEEP_IN,
  input  wire logic       RC_TICK_IN,
  // Conversion core
  input  wire logic [9:0] CONV_DATA,
  output logic            CONV_ENABLE,
  output logic            CONV_SAMPLE,
  output logic      [2:0] CHANNEL_SELECT,
  output logic      [1:0] REF_SELECT,
  output logic      [7:0] ANALOG_PINS,
  // Interrupt and wake
  output logic            IRQ,
  output logic            WAKE,
  output logic            WAKE_VECTOR
);
  logic [7:0]   ctrl0_r, ctrl1_r, pflag_r, pen_r, pinsel_r, irqc_r;
  logic         rd_mem_r;
  logic [7:0]   rd_reg_r, mem_rd;
  logic         rc_s1_r, rc_s2_r, rc_s3_r;
  logic [6:0]   div_r;
  logic [6:0]   div_top;
  logic         bitp_tick;
  logic [3:0]   bit_cnt_r, wait_cnt_r;
  adcsq_state_t state_r, state_nxt;
  logic         done_pulse, abort, asleep_off_r;
  logic [7:0]   res_hi, res_lo;
  logic         go_set;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Pin-level tick from the RC oscillator is resynchronised
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else if (CE) begin
      rc_s1_r <= RC_TICK_IN;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  wire [2:0] csel  = ctrl1_r[CS_LSB +: 3];
  wire       rc_on = (csel == CS_RC);

  always_comb begin
    case (csel) // R16
      CS_DIV2:  div_top = DIV2_TOP;
      CS_DIV8:  div_top = DIV8_TOP;
      CS_DIV32: div_top = DIV32_TOP;
      CS_DIV4:  div_top = DIV4_TOP;
      CS_DIV16: div_top = DIV16_TOP;
      CS_DIV64: div_top = DIV64_TOP;
      default:  div_top = RC_CYC;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      div_r <= '0;
    end else if (CE) begin
      if (state_r != ADCSQ_CONV || div_r == div_top) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 7'h01;
      end
    end
  end

  // One bit period per synchronised RC rising edge or divider wrap
  assign bitp_tick = rc_on ? (rc_s2_r & ~rc_s3_r)
                           : (div_r == div_top);

  // Sleep outside idle kills the converter unless RC clocking carries it through
  assign abort = SLEEP_IN && !rc_on && state_r != ADCSQ_IDLE; // R9
  assign go_set = CE && WR && hit(ADDR, OFF_CTRL0) && WDATA[B_GO]
                  && WDATA[B_PWR] && state_r == ADCSQ_IDLE;
  assign done_pulse = CE && state_r == ADCSQ_CONV && bitp_tick
                      && bit_cnt_r == NBITS - 4'h1 && !abort;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCSQ_IDLE: if (go_set) state_nxt = rc_on ? ADCSQ_WAIT : ADCSQ_CONV;
      ADCSQ_WAIT: if (wait_cnt_r == INSTR_CYC - 4'h1) state_nxt = ADCSQ_CONV;
      ADCSQ_CONV: if (done_pulse) state_nxt = ADCSQ_IDLE;
      default:    state_nxt = ADCSQ_IDLE;
    endcase
    // Start written together with power counts as powered
    if (abort || (!ctrl0_r[B_PWR] && !go_set)) state_nxt = ADCSQ_IDLE;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ADCSQ_IDLE; // R10
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  // One instruction of delay lets the sleep instruction retire first
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wait_cnt_r <= '0;
    end else if (CE) begin
      if (state_r == ADCSQ_WAIT) begin
        wait_cnt_r <= wait_cnt_r + 4'h1; // R4
      end else begin
        wait_cnt_r <= '0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      bit_cnt_r <= '0;
    end else if (CE) begin
      if (state_r != ADCSQ_CONV) begin
        bit_cnt_r <= '0;
      end else if (bitp_tick) begin
        bit_cnt_r <= bit_cnt_r + 4'h1; // R17
      end
    end
  end

  always_comb begin
    if (ctrl0_r[B_JUST]) begin // R12
      res_hi = {6'h00, CONV_DATA[9:8]};
      res_lo = CONV_DATA[7:0];
    end else begin
      res_hi = CONV_DATA[9:2];
      res_lo = {CONV_DATA[1:0], 6'h00};
    end
  end

  adcsq_result_mem u_res (
    .clk       (CLOCK),
    .ce        (CE),
    .wr_en     (done_pulse), // R5 R11
    .wr_hi     (res_hi),
    .wr_lo     (res_lo),
    .rd_sel_lo (hit(ADDR, OFF_RESLO)),
    .rd_data   (mem_rd)
  );

  // Control register: hardware clears start at done or abort
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrl0_r <= RST_ZERO; // R10
    end else if (CE) begin
      if (WR && hit(ADDR, OFF_CTRL0)) begin
        ctrl0_r <= WDATA;
        if (state_r != ADCSQ_IDLE) ctrl0_r[B_GO] <= 1'b1;
        if (!WDATA[B_PWR]) ctrl0_r[B_GO] <= 1'b0;
      end
      if (done_pulse || abort) ctrl0_r[B_GO] <= 1'b0; // R2 R5
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrl1_r <= RST_ZERO;
      pen_r   <= RST_ZERO;
      pinsel_r <= RST_PINSEL;
      irqc_r  <= RST_ZERO;
    end else if (CE && WR) begin
      if (hit(ADDR, OFF_CLKSEL)) begin
        ctrl1_r <= WDATA & CTRL1_MASK;
      end else if (hit(ADDR, OFF_PEN)) begin
        pen_r <= WDATA;
      end else if (hit(ADDR, OFF_PINSEL)) begin
        pinsel_r <= WDATA;
      end else if (hit(ADDR, OFF_IRQCON)) begin
        irqc_r <= WDATA & IRQC_MASK;
      end
    end
  end

  // Done flag: write one clears; completion wins over the clear
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pflag_r <= RST_ZERO;
    end else if (CE) begin
      if (WR && hit(ADDR, OFF_PFLAG)) pflag_r <= pflag_r & ~WDATA;
      if (done_pulse) pflag_r[B_DONE] <= 1'b1; // R13
    end
  end

  wire done_en = pen_r[B_DONE];

  // Sleep completion with the enable clear shuts the core, power bit kept
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      asleep_off_r <= 1'b0;
    end else if (CE) begin
      if ((done_pulse && SLEEP_IN && !done_en) || abort) begin
        asleep_off_r <= 1'b1; // R8 R9
      end else if (!SLEEP_IN || !ctrl0_r[B_PWR]) begin
        asleep_off_r <= 1'b0;
      end
    end
  end

  assign IRQ = pflag_r[B_DONE] && done_en && irqc_r[B_PERIE]
               && irqc_r[B_GLBIE]; // R13
  assign WAKE = SLEEP_IN && pflag_r[B_DONE] && done_en; // R6
  assign WAKE_VECTOR = WAKE && irqc_r[B_GLBIE]; // R7
  assign CONV_ENABLE = ctrl0_r[B_PWR] && !asleep_off_r; // R10
  assign CONV_SAMPLE = state_r == ADCSQ_IDLE && CONV_ENABLE;
  assign CHANNEL_SELECT = ctrl0_r[CH_LSB +: 3];
  assign REF_SELECT = ctrl0_r[REF_LSB +: 2];
  assign ANALOG_PINS = pinsel_r;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rd_reg_r <= RST_ZERO;
      rd_mem_r <= 1'b0;
    end else if (CE) begin
      rd_mem_r <= RD && (hit(ADDR, OFF_RESHI) || hit(ADDR, OFF_RESLO));
      if (!RD) rd_reg_r <= RST_ZERO;
      else if (hit(ADDR, OFF_CTRL0))  rd_reg_r <= ctrl0_r;
      else if (hit(ADDR, OFF_CLKSEL)) rd_reg_r <= ctrl1_r;
      else if (hit(ADDR, OFF_PFLAG))  rd_reg_r <= pflag_r;
      else if (hit(ADDR, OFF_PEN))    rd_reg_r <= pen_r;
      else if (hit(ADDR, OFF_PINSEL)) rd_reg_r <= pinsel_r;
      else if (hit(ADDR, OFF_IRQCON)) rd_reg_r <= irqc_r;
      else rd_reg_r <= RST_ZERO;
    end
  end

  assign RDATA = rd_mem_r ? mem_rd : rd_reg_r;

  a_go_clears: assert property (@(posedge CLOCK) disable iff (!NRST) // R2
    done_pulse |=> !ctrl0_r[B_GO]) else $error("start flag not cleared");
  a_flag_sets: assert property (@(posedge CLOCK) disable iff (!NRST) // R13
    done_pulse |=> pflag_r[B_DONE]) else $error("done flag not set");
  a_rc_delay: assert property (@(posedge CLOCK) disable iff (!NRST) // R4
    (go_set && rc_on) |=> state_r == ADCSQ_WAIT)
    else $error("rc start not delayed");
  a_abort_sleep: assert property (@(posedge CLOCK) disable iff (!NRST) // R9
    abort && CE |=> state_r == ADCSQ_IDLE && !CONV_ENABLE)
    else $error("sleep did not abort");
  a_wake_vec: assert property (@(posedge CLOCK) disable iff (!NRST) // R7
    WAKE_VECTOR |-> IRQ) else $error("vector without irq");
  // Completion in sleep with the enable set must raise wake next cycle
  a_wake_cond: assert property (@(posedge CLOCK) disable iff (!NRST) // R6
    (done_pulse && SLEEP_IN && done_en) |=> WAKE || !SLEEP_IN || !done_en)
    else $error("no wake after sleep completion");
  a_off_keeps: assert property (@(posedge CLOCK) disable iff (!NRST) // R8
    (CE && done_pulse && SLEEP_IN && !done_en) |=> !CONV_ENABLE
    && ctrl0_r[B_PWR]) else $error("power bit lost");
  a_conv_len: assert property (@(posedge CLOCK) disable iff (!NRST) // R17
    state_r == ADCSQ_CONV |-> bit_cnt_r < NBITS)
    else $error("bit count overran");
  // Fastest divider: ticks exactly every second clock while converting
  a_div_sel: assert property (@(posedge CLOCK) disable iff (!NRST) // R16
    (CE && bitp_tick && csel == CS_DIV2 && state_r == ADCSQ_CONV
     && !done_pulse && !abort) |=> !bitp_tick
    ##1 (bitp_tick || !$past(CE) || state_r != ADCSQ_CONV))
    else $error("divide by two spacing wrong");
  // Main scenarios
  c_conv: cover property (@(posedge CLOCK) done_pulse);
  c_abort: cover property (@(posedge CLOCK) abort);
  c_wake: cover property (@(posedge CLOCK) WAKE_VECTOR);
  c_rc_wait: cover property (@(posedge CLOCK) state_r == ADCSQ_WAIT);
  c_sleep_off: cover property (@(posedge CLOCK) $rose(asleep_off_r));
endmodule

// File: rtl/adcsq_pkg.sv
// Package: register map, field positions and timing for the conversion sequencer
package adcsq_pkg;
  // Register offsets (byte addresses, 8-bit address space)
  localparam logic [7:0] OFF_PFLAG  = 8'h0C;
  localparam logic [7:0] OFF_RESHI  = 8'h1E;
  localparam logic [7:0] OFF_CTRL0  = 8'h1F;
  localparam logic [7:0] OFF_PEN    = 8'h8C;
  localparam logic [7:0] OFF_PINSEL = 8'h91;
  localparam logic [7:0] OFF_RESLO  = 8'h9E;
  localparam logic [7:0] OFF_CLKSEL = 8'h9F;
  localparam logic [7:0] OFF_IRQCON = 8'h0B;
  // Reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_PINSEL = 8'hFF;
  // Field positions
  localparam int B_PWR    = 0;
  localparam int B_GO     = 1;
  localparam int B_JUST   = 7;
  localparam int B_DONE   = 6;
  localparam int B_PERIE  = 6;
  localparam int B_GLBIE  = 7;
  localparam int CS_LSB   = 4;
  localparam int CH_LSB   = 2;
  localparam int REF_LSB  = 5;
  localparam logic [7:0] CTRL1_MASK = 8'h70;
  localparam logic [7:0] IRQC_MASK  = 8'hC0;
  // Clock select codes
  localparam logic [2:0] CS_DIV2  = 3'h0;
  localparam logic [2:0] CS_DIV8  = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_RC    = 3'h3;
  localparam logic [2:0] CS_DIV4  = 3'h4;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  // Divider terminal counts: one bit period is top plus one clocks
  localparam logic [6:0] DIV2_TOP  = 7'h01;
  localparam logic [6:0] DIV4_TOP  = 7'h03;
  localparam logic [6:0] DIV8_TOP  = 7'h07;
  localparam logic [6:0] DIV16_TOP = 7'h0F;
  localparam logic [6:0] DIV32_TOP = 7'h1F;
  localparam logic [6:0] DIV64_TOP = 7'h3F;
  // Timing
  localparam int RES_BITS   = 10;
  localparam int BIT_PERIODS = 11;
  localparam int CLK_MHZ    = 250;
  localparam int INSTR_CLKS = 4;
  localparam int RC_DIV     = 64;
  localparam logic [3:0] INSTR_CYC  = 4'(INSTR_CLKS);
  localparam logic [6:0] RC_CYC     = 7'(RC_DIV - 1);
  localparam logic [3:0] NBITS      = 4'(BIT_PERIODS);
  localparam logic [15:0] POR_MARK  = 16'hA5C3;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_WAIT = 2'b01,
    ADCSQ_CONV = 2'b11
  } adcsq_state_t;
endpackage

// File: rtl/adcsq_result_mem.sv
// Result register pair, held across resets other than power-on
`timescale 1ns/1ps
module adcsq_result_mem
  import adcsq_pkg::*;
(
  // Clock
  input  wire logic       clk,
  input  wire logic       ce,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_hi,
  input  wire logic [7:0] wr_lo,
  // Read side
  input  wire logic       rd_sel_lo,
  output logic      [7:0] rd_data
);
  logic [7:0] mem_r [0:1];

  // No reset: contents survive every reset source
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem_r[0] <= wr_hi;
      mem_r[1] <= wr_lo;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rd_data <= mem_r[rd_sel_lo];
    end
  end
endmodule

// File: test/adcsq_core_model.sv
// Analog core model: conversion value and dedicated RC oscillator
`timescale 1ns/1ps
module adcsq_core_model (
  // Core controls
  input  wire logic       en,
  input  wire logic [2:0] ch,
  // Core outputs
  output logic      [9:0] data,
  output logic            rc_tick
);
  logic [9:0] last_r;
  initial begin
    rc_tick = 1'b0;
    last_r  = 10'h000;
  end
  // Free running, phase unrelated to the system clock
  always #21 rc_tick = ~rc_tick;
  always @(en or ch) begin
    if (en) last_r = {ch, 7'h35};
  end
  // Powered-off core shows a stable value, the inverse of the last value
  assign data = en ? {ch, 7'h35} : ~last_r;
endmodule

// File: test/adcsq_top_test.sv
// Testbench: registers, conversions, sleep, abort and reset
`timescale 1ns/1ps
module adcsq_top_test;
  import adcsq_pkg::*;
  logic       CLOCK = 1'b0;
  logic       NRST = 1'b0;
  logic       CE = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       SLEEP_IN = 1'b0;
  logic [7:0] RDATA, ANALOG_PINS;
  logic [9:0] CONV_DATA;
  logic [2:0] CHANNEL_SELECT;
  logic [1:0] REF_SELECT;
  logic       CONV_ENABLE, CONV_SAMPLE, IRQ, WAKE, WAKE_VECTOR, RC_TICK_IN;
  int         errors = 0;
  int         n_tests = 0;
  int         dv[7] = '{2, 8, 32, 0, 4, 16, 64};

  always #2 CLOCK = ~CLOCK;

  adcsq_top adcsq_top_i (.CLOCK(CLOCK), .NRST(NRST), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP_IN(SLEEP_IN),
    .RC_TICK_IN(RC_TICK_IN), .CONV_DATA(CONV_DATA),
    .CONV_ENABLE(CONV_ENABLE), .CONV_SAMPLE(CONV_SAMPLE),
    .CHANNEL_SELECT(CHANNEL_SELECT), .REF_SELECT(REF_SELECT),
    .ANALOG_PINS(ANALOG_PINS), .IRQ(IRQ), .WAKE(WAKE),
    .WAKE_VECTOR(WAKE_VECTOR));
  adcsq_core_model adcsq_core_model_i (.en(CONV_ENABLE),
    .ch(CHANNEL_SELECT), .data(CONV_DATA), .rc_tick(RC_TICK_IN));

  task automatic final_report();
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, e);
    logic [7:0] d;
    rd(a, d);
    chk8(nm, e, d);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return CONV_SAMPLE;
      1: return WAKE;
      default: return !CONV_ENABLE;
    endcase
  endfunction
  task automatic wait_hi(input int w, lim, output int n);
    n = 0;
    #1;
    while (sig(w) !== 1'b1) begin
      @(posedge CLOCK);
      #1 n++;
      if (n > lim) begin
        errors++;
        final_report();
      end
    end
  endtask
  task automatic start(input logic [2:0] cs, input logic [7:0] c0);
    wr(OFF_CLKSEL, {1'b0, cs, 4'h0});
    wr(OFF_CTRL0, c0 | 8'h01);
    // Acquisition time before the start flag
    repeat (8) @(posedge CLOCK);
    wr(OFF_CTRL0, c0 | 8'h03);
  endtask

  task automatic t_regs();
    logic [7:0] ad[7] = '{OFF_PFLAG, OFF_CTRL0, OFF_PEN, OFF_PINSEL,
                          OFF_CLKSEL, OFF_IRQCON, 8'h55};
    for (int i = 0; i < 7; i++)
      rchk("reset", ad[i], ad[i] == OFF_PINSEL ? 8'hFF : 8'h00);
    wr(OFF_CLKSEL, 8'hFF);
    rchk("clksel", OFF_CLKSEL, 8'h70);
    wr(OFF_PINSEL, 8'h5A);
    rchk("pinsel", OFF_PINSEL, 8'h5A);
    chk8("pins", 8'h5A, ANALOG_PINS);
    wr(OFF_PINSEL, 8'hFF);
    // Frozen clock enable: a write must not land
    CE <= 1'b0;
    wr(OFF_PEN, 8'hFF);
    CE <= 1'b1;
    rchk("ce hold", OFF_PEN, 8'h00);
    // Start without power is refused
    wr(OFF_CTRL0, 8'h02);
    rchk("no start", OFF_CTRL0, 8'h00);
  endtask

  task automatic t_conv(input logic [2:0] cs, input int per, input bit rj);
    logic [7:0] c0;
    logic [9:0] v;
    int n, lo, hi;
    c0 = {rj, 2'b10, cs, 2'b00};
    v = {cs, 7'h35};
    lo = (cs == CS_RC) ? 104 : 11 * per;
    hi = (cs == CS_RC) ? 131 : 11 * per + 6;
    start(cs, c0);
    #1 chk1("ref ch", 1'b1, REF_SELECT === 2'b10 && CHANNEL_SELECT === cs);
    wait_hi(0, 2000, n);
    chk1("duration", 1'b1, n >= lo && n <= hi);
    rchk("go clr", OFF_CTRL0, c0 | 8'h01);
    rchk("flag", OFF_PFLAG, 8'h40);
    rchk("high", OFF_RESHI, rj ? {6'h00, v[9:8]} : v[9:2]);
    rchk("low", OFF_RESLO, rj ? v[7:0] : {v[1:0], 6'h00});
    wr(OFF_PFLAG, 8'h40);
    rchk("flag clr", OFF_PFLAG, 8'h00);
    // Two bit periods before the next acquisition
    repeat (130) @(posedge CLOCK);
  endtask

  task automatic t_sleep(input bit en, global_irq_enable);
    int n;
    wr(OFF_PEN, {1'b0, en, 6'h00});
    wr(OFF_IRQCON, {global_irq_enable, 7'h40});
    start(CS_RC, 8'h04);
    SLEEP_IN <= 1'b1;
    wait_hi(en ? 1 : 2, 400, n);
    if (en) begin
      chk1("vector", global_irq_enable, WAKE_VECTOR);
      chk1("irq", global_irq_enable, IRQ);
    end
    rchk("power kept", OFF_CTRL0, 8'h05);
    rchk("flag", OFF_PFLAG, 8'h40);
    wr(OFF_PEN, 8'h00);
    @(posedge CLOCK);
    #1 chk1("masked", 1'b0, IRQ | WAKE);
    @(posedge CLOCK);
    SLEEP_IN <= 1'b0;
    wr(OFF_PFLAG, 8'h40);
    wr(OFF_CTRL0, 8'h00);
  endtask

  task automatic t_abort();
    logic [7:0] d;
    start(CS_DIV64, 8'h00);
    repeat (20) @(posedge CLOCK);
    SLEEP_IN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    #1 chk1("abort off", 1'b0, CONV_ENABLE);
    repeat (800) @(posedge CLOCK);
    rd(OFF_CTRL0, d);
    chk1("power kept", 1'b1, d[0]);
    rchk("no done", OFF_PFLAG, 8'h00);
    @(posedge CLOCK);
    SLEEP_IN <= 1'b0;
    wr(OFF_CTRL0, 8'h00);
  endtask

  task automatic t_reset();
    logic [7:0] h, l;
    rd(OFF_RESHI, h);
    rd(OFF_RESLO, l);
    start(CS_DIV64, 8'h14);
    repeat (50) @(posedge CLOCK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1 chk1("rst off", 1'b0, CONV_ENABLE);
    @(posedge CLOCK);
    NRST <= 1'b1;
    repeat (800) @(posedge CLOCK);
    rchk("ctrl0", OFF_CTRL0, 8'h00);
    rchk("clksel", OFF_CLKSEL, 8'h00);
    rchk("flag", OFF_PFLAG, 8'h00);
    rchk("high kept", OFF_RESHI, h);
    rchk("low kept", OFF_RESLO, l);
  endtask

  initial begin
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    t_regs();
    for (int i = 0; i < 7; i++) t_conv(3'(i), dv[i], i[0]);
    t_sleep(1'b1, 1'b1);
    t_sleep(1'b1, 1'b0);
    t_sleep(1'b0, 1'b1);
    t_abort();
    t_reset();
    final_report();
  end
endmodule
